// ### cipher_params.svh
/*
 * Register map, field positions, bit masks and timing figures of the
 * block-cipher register front end.
 * Assumes it is included by bare name into each file that needs it.
 */
// Notes on behaviour
// - mask view reads 1 per enabled interrupt: bits 0,1,2,3,4 and 8.
// - output ready sets on completion, clears on manual start or soft reset.
// - manual/auto, last-output off: reading a result word clears output ready.
// - manual/auto, last-output on: writing an input word clears output ready.
// - DMA mode: output ready sets and clears by itself.
// - rx end sets when receive count reaches 0 since last count write.
// - tx end sets when transmit count reaches 0 since last count write.
// - rx full reads 1 exactly when both receive counts are zero.
// - tx empty reads 1 exactly when both transmit counts are zero.
// - bad access flag is sticky until soft reset only.
// - bad access kind: 0 input busy, 1 result busy, 2 mode busy, 3 wo read.
// - bad access kind keeps the latest violation, cleared by soft reset only.
// - each key is two 32-bit words, word one is the upper part.
// - key words are write-only and never read back.
// - single mode ignores the second key.
// - third key ignored in single mode and in two-key triple mode.
// - input block is two write-only words, word one upper part.
// - result block reads as two words, word one upper part.
// - init vector is two write-only words, used by chaining modes.
// - writing 1 to start begins a manual run; 0 does nothing.
// - enable writes set mask bits, disable writes clear them.
`ifndef CIPHER_PARAMS_SVH
`define CIPHER_PARAMS_SVH

`define ADDR_W 9
`define CNT_W 16
`define ROUNDS 16

`define OFS_CTRL 9'h000
`define OFS_MODE 9'h004
`define OFS_IEN 9'h010
`define OFS_IDIS 9'h014
`define OFS_IMASK 9'h018
`define OFS_FLAGS 9'h01c
`define OFS_KEY1W1 9'h020
`define OFS_KEY1W2 9'h024
`define OFS_KEY2W1 9'h028
`define OFS_KEY2W2 9'h02c
`define OFS_KEY3W1 9'h030
`define OFS_KEY3W2 9'h034
`define OFS_IN1 9'h040
`define OFS_IN2 9'h044
`define OFS_OUT1 9'h050
`define OFS_OUT2 9'h054
`define OFS_IV1 9'h060
`define OFS_IV2 9'h064
`define OFS_RCNT 9'h104
`define OFS_TCNT 9'h10c
`define OFS_RNEXT 9'h114
`define OFS_TNEXT 9'h11c

`define BIT_START 0
`define BIT_SOFT_RESET_COMMAND 8
`define BIT_ENC 0
`define BIT_TRIPLE 1
`define BIT_TWOKEY 4
`define BIT_LOD 15
`define START_MODE_SELECT_LSB 8
`define OPMOD_LSB 12
`define MODE_BITS 32'h0003b313
`define IRQ_BITS 32'h0000011f
`define KIND_LSB 12
`define BIT_BAD 8

`endif

// ### cipher_pkg.sv
/*
 * Types shared by the cipher register front end and its processing core.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cipher_pkg;
   typedef enum logic [1:0] {
      START_MANUAL = 2'h0,
      START_AUTO = 2'h1,
      START_DMA = 2'h2,
      START_RSVD = 2'h3
   } start_mode_type;
   typedef enum logic [1:0] {
      KIND_IN_WR = 2'h0,
      KIND_OUT_RD = 2'h1,
      KIND_MODE_WR = 2'h2,
      KIND_WO_RD = 2'h3
   } bad_kind_type;
   typedef enum logic [1:0] {
      CORE_IDLE = 2'h1,
      CORE_RUN = 2'h2
   } core_state_type;
endpackage : cipher_pkg

// ### cipher_core.sv
/*
 * Iterating block core: takes one 64-bit block, runs a fixed number of
 * rounds, returns the block with a one-cycle done pulse.
 * Assumes keys and block stay stable while busy; the round is a stand-in.
 */
`include "cipher_params.svh"
module cipher_core #(
   parameter int ROUNDS = `ROUNDS
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic abort,
   input wire logic go,
   input wire logic triple_select,
   input wire logic two_key_select,
   input wire logic encrypt,
   input wire logic [63:0] key1,
   input wire logic [63:0] key2,
   input wire logic [63:0] key3,
   input wire logic [63:0] din,
   output logic busy,
   output logic done,
   output logic [63:0] dout
);
   import cipher_pkg::*;
   localparam int CW = $clog2(ROUNDS + 1);
   if (ROUNDS < 1) begin : g_bad_rounds
      $error("ROUNDS must be at least 1");
   end
   core_state_type state_ff;
   logic [CW-1:0] cnt_ff;
   logic [63:0] data_ff;
   logic done_ff;
   wire [63:0] key_eff;
   wire [63:0] rot;
   assign key_eff = key1 ^ (triple_select ? key2 : 64'h0)
      ^ ((triple_select && !two_key_select) ? key3 : 64'h0);
   assign rot = encrypt ? {data_ff[62:0], data_ff[63]} : {data_ff[0], data_ff[63:1]};
   assign busy = (state_ff == CORE_RUN);
   assign done = done_ff;
   assign dout = data_ff;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= CORE_IDLE;
         cnt_ff <= '0;
         data_ff <= 64'h0;
         done_ff <= 1'b0;
      end else if (abort) begin
         state_ff <= CORE_IDLE;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         unique case (state_ff)
            CORE_IDLE: begin
               if (go) begin
                  data_ff <= din;
                  cnt_ff <= CW'(ROUNDS - 1);
                  state_ff <= CORE_RUN;
               end
            end
            CORE_RUN: begin
               data_ff <= rot ^ key_eff;
               if (cnt_ff == '0) begin
                  state_ff <= CORE_IDLE;
                  done_ff <= 1'b1;
               end else begin
                  cnt_ff <= cnt_ff - 1'b1;
               end
            end
            default: state_ff <= CORE_IDLE;
         endcase
      end
   end
endmodule : cipher_core

// ### cipher_regs.sv
/*
 * Register front end of the triple block cipher: control, mode, mask,
 * status, key/input/vector stores, result words and DMA counters.
 * Assumes a same-clock register master and a same-clock DMA channel.
 */
// The implementer's own choices: the placing of the registers and strobed register access.
`include "cipher_params.svh"
module cipher_regs #(
   parameter int ROUNDS = `ROUNDS,
   parameter int CNT_W = `CNT_W
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic dma_rx_beat,
   input wire logic dma_tx_beat,
   output logic [31:0] rdata,
   output logic irq,
   output logic dma_rx_req,
   output logic dma_tx_req
);
   import cipher_pkg::*;
   if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
      $error("CNT_W must be 1 to 32");
   end

   // ----------------------------------------
   // decode
   // ----------------------------------------
   localparam logic [`ADDR_W-1:0] WORD_OFS [10] = '{`OFS_KEY1W1, `OFS_KEY1W2,
      `OFS_KEY2W1, `OFS_KEY2W2, `OFS_KEY3W1, `OFS_KEY3W2, `OFS_IN1, `OFS_IN2,
      `OFS_IV1, `OFS_IV2};
   localparam logic [`ADDR_W-1:0] CNT_OFS [2] = '{`OFS_RCNT, `OFS_TCNT};
   localparam logic [`ADDR_W-1:0] NEXT_OFS [2] = '{`OFS_RNEXT, `OFS_TNEXT};

   logic [31:0] word_ff [10];
   logic [63:0] result_ff;
   logic [31:0] mode_ff;
   logic [31:0] mask_ff;
   logic ready_ff;
   logic bad_ff;
   bad_kind_type kind_ff;
   logic [1:0] in_seen_ff;
   logic [CNT_W-1:0] cnt_ff [2];
   logic [CNT_W-1:0] next_ff [2];
   logic [1:0] end_ff;
   logic [31:0] rdata_ff;
   logic irq_ff;
   logic rx_req_ff;
   logic tx_req_ff;

   wire [9:0] word_hit;
   wire [9:0] word_we;
   wire [1:0] cnt_hit;
   wire [1:0] next_hit;
   wire [1:0] zero_both;
   wire [1:0] beat = {dma_tx_beat, dma_rx_beat};
   wire hit_ctrl = (addr == `OFS_CTRL);
   wire hit_mode = (addr == `OFS_MODE);
   wire hit_ien = (addr == `OFS_IEN);
   wire hit_idis = (addr == `OFS_IDIS);
   wire hit_imask = (addr == `OFS_IMASK);
   wire hit_flags = (addr == `OFS_FLAGS);
   wire hit_out1 = (addr == `OFS_OUT1);
   wire hit_out2 = (addr == `OFS_OUT2);
   wire hit_out = hit_out1 || hit_out2;
   wire hit_in = word_hit[6] || word_hit[7];
   wire hit_wo = hit_ctrl || hit_ien || hit_idis || (|word_hit);

   // ----------------------------------------
   // mode fields and core
   // ----------------------------------------
   start_mode_type start_mode_select;
   assign start_mode_select = start_mode_type'(mode_ff[`START_MODE_SELECT_LSB+1:`START_MODE_SELECT_LSB]);
   wire dma_mode = (start_mode_select == START_DMA);
   wire sw_mode = (start_mode_select == START_MANUAL) || (start_mode_select == START_AUTO);
   wire last_output_mode = mode_ff[`BIT_LOD];
   wire chain = (mode_ff[`OPMOD_LSB+1:`OPMOD_LSB] != 2'h0);
   wire busy;
   wire done;
   wire [63:0] core_out;

   wire soft_reset_command = wr && hit_ctrl && wdata[`BIT_SOFT_RESET_COMMAND];
   wire start_cmd = wr && hit_ctrl && wdata[`BIT_START];
   wire auto_go = (in_seen_ff == 2'h3) && (start_mode_select == START_AUTO || dma_mode);
   wire go = !busy && !soft_reset_command && (start_cmd || auto_go);
   wire in_wr_busy = wr && hit_in && busy && dma_mode;
   wire in_wr_ok = wr && hit_in && !in_wr_busy;
   wire out_rd_busy = rd && hit_out && busy;
   wire mode_wr_busy = wr && hit_mode && busy;
   wire wo_rd = rd && hit_wo;
   wire bad_ev = in_wr_busy || out_rd_busy || mode_wr_busy || wo_rd;
   bad_kind_type ev_kind;
   assign ev_kind = wo_rd ? KIND_WO_RD : mode_wr_busy ? KIND_MODE_WR :
      out_rd_busy ? KIND_OUT_RD : KIND_IN_WR;

   cipher_core #(.ROUNDS(ROUNDS)) u_core (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .abort(soft_reset_command),
      .go(go),
      .triple_select(mode_ff[`BIT_TRIPLE]),
      .two_key_select(mode_ff[`BIT_TWOKEY]),
      .encrypt(mode_ff[`BIT_ENC]),
      .key1({word_ff[0], word_ff[1]}),
      .key2({word_ff[2], word_ff[3]}),
      .key3({word_ff[4], word_ff[5]}),
      .din({word_ff[6], word_ff[7]} ^ (chain ? {word_ff[8], word_ff[9]} : 64'h0)),
      .busy(busy),
      .done(done),
      .dout(core_out)
   );

   // ----------------------------------------
   // write-only word stores
   // ----------------------------------------
   for (genvar i = 0; i < 10; i++) begin : g_word
      assign word_hit[i] = (addr == WORD_OFS[i]);
      assign word_we[i] = wr && word_hit[i] && !(i >= 6 && i <= 7 && in_wr_busy);
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            word_ff[i] <= 32'h0;
         end else if (word_we[i]) begin
            word_ff[i] <= wdata;
         end else if (i >= 8 && done && chain) begin
            word_ff[i] <= (i == 8) ? core_out[63:32] : core_out[31:0];
         end
      end
   end

   // ----------------------------------------
   // DMA transfer counters
   // ----------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_chan
      assign cnt_hit[c] = wr && (addr == CNT_OFS[c]);
      assign next_hit[c] = wr && (addr == NEXT_OFS[c]);
      assign zero_both[c] = (cnt_ff[c] == '0) && (next_ff[c] == '0);
      wire reach0 = beat[c] && (cnt_ff[c] == CNT_W'(1));
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            cnt_ff[c] <= '0;
            next_ff[c] <= '0;
            end_ff[c] <= 1'b0;
         end else if (soft_reset_command) begin
            cnt_ff[c] <= '0;
            next_ff[c] <= '0;
            end_ff[c] <= 1'b0;
         end else begin
            if (cnt_hit[c]) begin
               cnt_ff[c] <= wdata[CNT_W-1:0];
            end else if (reach0) begin
               cnt_ff[c] <= next_ff[c];
            end else if (beat[c] && cnt_ff[c] != '0) begin
               cnt_ff[c] <= cnt_ff[c] - 1'b1;
            end
            if (next_hit[c]) begin
               next_ff[c] <= wdata[CNT_W-1:0];
            end else if (reach0 && !cnt_hit[c]) begin
               next_ff[c] <= '0;
            end
            end_ff[c] <= reach0 || (end_ff[c] && !cnt_hit[c] && !next_hit[c]);
         end
      end
   end

   // ----------------------------------------
   // status and output ready
   // ----------------------------------------
   wire rdy_clr = start_cmd
      || (sw_mode && !last_output_mode && rd && hit_out)
      || (sw_mode && last_output_mode && in_wr_ok)
      || (dma_mode && go);
   wire nxt_ready = soft_reset_command ? 1'b0 : (done || (ready_ff && !rdy_clr));
   wire nxt_bad = !soft_reset_command && (bad_ff || bad_ev);
   bad_kind_type nxt_kind;
   assign nxt_kind = soft_reset_command ? KIND_IN_WR : bad_ev ? ev_kind : kind_ff;
   wire [31:0] status_word = {18'h0, kind_ff, 3'h0, bad_ff, 3'h0,
      zero_both[1], zero_both[0], end_ff[1], end_ff[0], ready_ff};
   wire [31:0] nxt_mask = soft_reset_command ? 32'h0 :
      ((mask_ff | (wr && hit_ien ? wdata : 32'h0)) &
      ~(wr && hit_idis ? wdata : 32'h0)) & `IRQ_BITS;
   wire [31:0] rd_mux = hit_mode ? mode_ff :
      hit_imask ? mask_ff :
      hit_flags ? status_word :
      hit_out1 ? result_ff[63:32] :
      hit_out2 ? result_ff[31:0] :
      (addr == `OFS_RCNT) ? 32'(cnt_ff[0]) :
      (addr == `OFS_TCNT) ? 32'(cnt_ff[1]) :
      (addr == `OFS_RNEXT) ? 32'(next_ff[0]) :
      (addr == `OFS_TNEXT) ? 32'(next_ff[1]) : 32'h0;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode_ff <= 32'h0;
         mask_ff <= 32'h0;
         ready_ff <= 1'b0;
         bad_ff <= 1'b0;
         kind_ff <= KIND_IN_WR;
         in_seen_ff <= 2'h0;
         result_ff <= 64'h0;
      end else begin
         if (soft_reset_command) begin
            mode_ff <= 32'h0;
         end else if (wr && hit_mode && !busy) begin
            mode_ff <= wdata & `MODE_BITS;
         end
         mask_ff <= nxt_mask;
         ready_ff <= nxt_ready;
         bad_ff <= nxt_bad;
         kind_ff <= nxt_kind;
         if (soft_reset_command || go) begin
            in_seen_ff <= 2'h0;
         end else if (in_wr_ok) begin
            in_seen_ff <= in_seen_ff | {word_hit[7], word_hit[6]};
         end
         if (done) begin
            result_ff <= core_out;
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= 32'h0;
         irq_ff <= 1'b0;
         rx_req_ff <= 1'b0;
         tx_req_ff <= 1'b0;
      end else begin
         rdata_ff <= rd ? rd_mux : 32'h0;
         irq_ff <= |(status_word & mask_ff);
         rx_req_ff <= dma_mode && !last_output_mode && ready_ff && (cnt_ff[0] != '0);
         tx_req_ff <= dma_mode && !busy && (in_seen_ff != 2'h3) && (cnt_ff[1] != '0);
      end
   end
   assign rdata = rdata_ff;
   assign irq = irq_ff;
   assign dma_rx_req = rx_req_ff;
   assign dma_tx_req = tx_req_ff;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   AST_RDY_SET: assert property (done && !soft_reset_command |=> ready_ff)
      else $error("output ready not set after completion");
   AST_RDY_START: assert property (start_cmd && !done |=> !ready_ff)
      else $error("output ready not cleared by start");
   AST_RDY_READ: assert property (sw_mode && !last_output_mode && rd && hit_out && !done
      |=> !ready_ff)
      else $error("output ready not cleared by result read");
   AST_RDY_WRITE: assert property (sw_mode && last_output_mode && in_wr_ok && !done
      |=> !ready_ff)
      else $error("output ready not cleared by input write");
   AST_BAD_STICKY: assert property (bad_ff && !soft_reset_command |=> bad_ff)
      else $error("bad access flag dropped without soft reset");
   AST_KIND_WO: assert property (wo_rd && !soft_reset_command |=> kind_ff == KIND_WO_RD && bad_ff)
      else $error("write-only read not recorded");
   AST_KEY_HIDDEN: assert property (rd && hit_wo |=> rdata_ff == 32'h0)
      else $error("write-only register returned data");
   AST_RXFULL: assert property (rd && hit_flags
      |=> rdata_ff[3] == $past(zero_both[0]) && rdata_ff[4] == $past(zero_both[1]))
      else $error("buffer flags disagree with counters");
   AST_IMASK: assert property (rd && hit_imask |=> rdata_ff == $past(mask_ff))
      else $error("mask view differs from mask");
   AST_IRQ: assert property (##1 irq_ff == $past(|(status_word & mask_ff)))
      else $error("interrupt output disagrees with enabled flags");
   AST_RXEND: assert property (beat[0] && cnt_ff[0] == CNT_W'(1) && !soft_reset_command
      |=> end_ff[0])
      else $error("rx end not set at count zero");

   COV_DONE: cover property (go ##[1:40] done);
   COV_BAD: cover property (out_rd_busy);
   COV_IRQ: cover property (!irq_ff ##1 irq_ff);
endmodule : cipher_regs

// ### dma_channel_model.sv
/*
 * Stand-in for the peripheral dma channel: writes input words and reads
 * result words of the register block, one beat per request.
 * Assumes the same clock as the register block and a bus mux in the bench.
 */
`include "cipher_params.svh"
module dma_channel_model (
   input wire logic clk_sys,
   input wire logic en,
   input wire logic tx_req,
   input wire logic rx_req,
   output logic [8:0] addr,
   output logic [31:0] wdata,
   output logic wr,
   output logic rd,
   output logic tx_beat,
   output logic rx_beat
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tx_w = 1'b0;
   logic rx_w = 1'b0;
   logic [3:0] n_xfer = 4'h0;
   // ----------------------------------------
   // one transfer per request, gap alternates between prompt and slow
   // ----------------------------------------
   initial begin
      {wr, rd, tx_beat, rx_beat} = 4'h0;
      addr = 9'h000;
      wdata = 32'h0;
      forever begin
         @(posedge clk_sys);
         #1;
         if (en && (tx_req || rx_req)) begin
            wr = tx_req;
            rd = !tx_req;
            tx_beat = tx_req;
            rx_beat = !tx_req;
            addr = tx_req ? (tx_w ? `OFS_IN2 : `OFS_IN1) : (rx_w ? `OFS_OUT2 : `OFS_OUT1);
            wdata = 32'hc0de0000 | {28'h0, n_xfer};
            if (tx_req) tx_w = !tx_w;
            else rx_w = !rx_w;
            @(posedge clk_sys);
            #1;
            {wr, rd, tx_beat, rx_beat} = 4'h0;
            // released lines show the inverse of the last value
            addr = ~addr;
            wdata = ~wdata;
            n_xfer = n_xfer + 4'h1;
            repeat (n_xfer[0] ? 1 : 5) @(posedge clk_sys);
         end
      end
   end
endmodule : dma_channel_model

// ### triple_des_status_and_data_regs_tb.sv
/*
 * Self-checking bench of the cipher register front end with a dma stand-in.
 * Assumes cipher_params.svh, cipher_pkg, cipher_core and dma_channel_model.
 */
`include "cipher_params.svh"
module triple_des_status_and_data_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cipher_pkg::*;
   localparam int RND = 8;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [8:0] t_addr = 9'h000;
   logic [31:0] t_wdata = 32'h0;
   logic t_wr = 1'b0;
   logic t_rd = 1'b0;
   logic dma_en = 1'b0;
   logic [8:0] m_addr;
   logic [31:0] m_wdata;
   logic m_wr, m_rd, tx_beat, rx_beat;
   logic [31:0] rdata;
   logic irq, rx_req, tx_req;
   int n_fail = 0;
   int checked = 0;
   wire logic m_own = m_wr | m_rd;
   wire logic [8:0] addr = m_own ? m_addr : t_addr;
   wire logic [31:0] wdata = m_own ? m_wdata : t_wdata;

   always #4 clk_sys = ~clk_sys;

   cipher_regs #(.ROUNDS(RND)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
      .wdata(wdata), .wr(t_wr | m_wr), .rd(t_rd | m_rd), .dma_rx_beat(rx_beat),
      .dma_tx_beat(tx_beat), .rdata(rdata), .irq(irq), .dma_rx_req(rx_req),
      .dma_tx_req(tx_req));

   dma_channel_model dma (.clk_sys(clk_sys), .en(dma_en), .tx_req(tx_req), .rx_req(rx_req),
      .addr(m_addr), .wdata(m_wdata), .wr(m_wr), .rd(m_rd), .tx_beat(tx_beat),
      .rx_beat(rx_beat));

   // ----------------------------------------
   // compares, bus cycles and closing
   // ----------------------------------------
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: register read %h, expected %h", $time, got, exp);
      end
   endtask : chk32

   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: interrupt %b, expected %b", $time, got, exp);
      end
   endtask : chk1

   task automatic bus_wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      t_addr <= a;
      t_wdata <= d;
      t_wr <= 1'b1;
      @(posedge clk_sys);
      t_wr <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [8:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      t_addr <= a;
      t_rd <= 1'b1;
      @(posedge clk_sys);
      t_rd <= 1'b0;
      #1;
      d = rdata;
   endtask : bus_rd

   task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus_rd(a, d);
      chk32(d, exp);
   endtask : rd_chk

   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge clk_sys);
      #1;
      chk1(irq, exp);
   endtask : irq_chk

   task automatic wait_done();
      repeat (RND + 3) @(posedge clk_sys);
   endtask : wait_done

   // manual run of one block, upper result word returned
   task automatic run_blk(input logic [31:0] mode, input logic [31:0] w1,
      output logic [31:0] r);
      bus_wr(`OFS_MODE, mode);
      bus_wr(`OFS_IN1, w1);
      bus_wr(`OFS_IN2, 32'h0);
      bus_wr(`OFS_CTRL, 32'h1);
      wait_done();
      bus_rd(`OFS_OUT1, r);
   endtask : run_blk

   task automatic tally_and_finish();
      if (n_fail == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   initial begin : watchdog
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      tally_and_finish();
   end

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin : main
      logic [31:0] d, r1, r2;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd_chk(`OFS_FLAGS, 32'h18);
      rd_chk(`OFS_IMASK, 32'h0);
      bus_wr(`OFS_IEN, 32'hffffffff);
      rd_chk(`OFS_IMASK, `IRQ_BITS);
      bus_wr(`OFS_IDIS, 32'h00000011);
      rd_chk(`OFS_IMASK, 32'h0000010e);
      irq_chk(1'b1);
      bus_wr(`OFS_IDIS, 32'hffffffff);
      irq_chk(1'b0);
      // manual start, last-output off, then on
      bus_wr(`OFS_MODE, 32'h1);
      bus_wr(`OFS_IN1, 32'h01234567);
      bus_wr(`OFS_IN2, 32'h89abcdef);
      bus_wr(`OFS_CTRL, 32'h1);
      wait_done();
      rd_chk(`OFS_FLAGS, 32'h19);
      bus_wr(`OFS_CTRL, 32'h0);
      wait_done();
      rd_chk(`OFS_FLAGS, 32'h19);
      bus_rd(`OFS_OUT2, d);
      rd_chk(`OFS_FLAGS, 32'h18);
      bus_wr(`OFS_CTRL, 32'h1);
      wait_done();
      bus_wr(`OFS_CTRL, 32'h1);
      rd_chk(`OFS_FLAGS, 32'h18);
      wait_done();
      rd_chk(`OFS_FLAGS, 32'h19);
      bus_wr(`OFS_MODE, 32'h8001);
      bus_wr(`OFS_IN1, 32'h0);
      rd_chk(`OFS_FLAGS, 32'h18);
      // auto start
      bus_wr(`OFS_MODE, 32'h101);
      bus_wr(`OFS_IN1, 32'h11111111);
      bus_wr(`OFS_IN2, 32'h22222222);
      wait_done();
      rd_chk(`OFS_FLAGS, 32'h19);
      bus_rd(`OFS_OUT1, d);
      rd_chk(`OFS_FLAGS, 32'h18);
      // violations while busy, then a write-only read
      bus_wr(`OFS_MODE, 32'h1);
      bus_wr(`OFS_CTRL, 32'h1);
      bus_rd(`OFS_OUT1, d);
      bus_wr(`OFS_MODE, 32'h101);
      wait_done();
      rd_chk(`OFS_FLAGS, 32'h2119);
      rd_chk(`OFS_MODE, 32'h1);
      rd_chk(`OFS_KEY2W1, 32'h0);
      rd_chk(`OFS_FLAGS, 32'h3119);
      bus_wr(`OFS_IEN, 32'h100);
      irq_chk(1'b1);
      bus_wr(`OFS_CTRL, 32'h100);
      rd_chk(`OFS_FLAGS, 32'h18);
      rd_chk(`OFS_IMASK, 32'h0);
      irq_chk(1'b0);
      rd_chk(9'h008, 32'h0);
      rd_chk(`OFS_FLAGS, 32'h18);
      // unused keys must not change the result; vector folds into the block
      bus_wr(`OFS_KEY1W1, 32'h5a5a0f0f);
      run_blk(32'h1, 32'h13579bdf, r1);
      bus_wr(`OFS_KEY2W1, 32'h00ff00ff);
      run_blk(32'h1, 32'h13579bdf, r2);
      chk32(r2, r1);
      run_blk(32'h13, 32'h13579bdf, r1);
      bus_wr(`OFS_KEY3W1, 32'h3c3c3c3c);
      run_blk(32'h13, 32'h13579bdf, r2);
      chk32(r2, r1);
      run_blk(32'h1, 32'h13579bdf ^ 32'h0badcafe, r1);
      bus_wr(`OFS_MODE, 32'h1001);
      bus_wr(`OFS_IV1, 32'h0badcafe);
      bus_wr(`OFS_IV2, 32'h0);
      run_blk(32'h1001, 32'h13579bdf, r2);
      chk32(r2, r1);
      // dma mode, last-output off, two blocks moved by the channel
      bus_wr(`OFS_MODE, 32'h201);
      bus_wr(`OFS_TCNT, 32'h4);
      bus_wr(`OFS_RCNT, 32'h4);
      rd_chk(`OFS_FLAGS, 32'h0);
      bus_wr(`OFS_IEN, 32'h2);
      dma_en <= 1'b1;
      for (int i = 0; i < 400 && irq !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk1(irq, 1'b1);
      dma_en <= 1'b0;
      rd_chk(`OFS_FLAGS, 32'h1f);
      bus_wr(`OFS_IN1, 32'h1);
      bus_wr(`OFS_IN2, 32'h2);
      bus_wr(`OFS_IN1, 32'h3);
      rd_chk(`OFS_FLAGS, 32'h11e);
      wait_done();
      bus_wr(`OFS_RCNT, 32'h1);
      rd_chk(`OFS_FLAGS, 32'h115);
      tally_and_finish();
   end
endmodule : triple_des_status_and_data_regs_tb
